// >>> hw/rsc_pkg.sv
// package: constants of the reset source controller
package rsc_pkg;
   // register byte offsets on the apb slave
   localparam logic [7:0] ADDR_CAUSE = 8'h00;
   localparam logic [7:0] ADDR_SYSCTL3 = 8'h04;
   localparam logic [7:0] ADDR_KEY = 8'h08;
   localparam logic [7:0] ADDR_STATE = 8'h0c;
   // reset_cause_status field positions
   localparam int CAUSE_VLT_BIT = 0;
   localparam int CAUSE_WDT_BIT = 1;
   localparam int CAUSE_CLK_BIT = 2;
   localparam int CAUSE_TRIMFAULT_BIT = 3;
   localparam int CAUSE_TRIMLOST_BIT = 4;
   localparam int CAUSE_FLASH_BIT = 5;
   localparam int CAUSE_CLEARREQ_BIT = 7;
   localparam int CAUSE_FLAGS = 6;
   localparam logic [CAUSE_FLAGS-1:0] CAUSE_RESET = 6'h00;
   // system_control_three field
   localparam int SYSCTL3_PINDIS_BIT = 0;
   // status register fields
   localparam int STATE_WARMUP_BIT = 0;
   localparam int STATE_RUN_BIT = 1;
   localparam int STATE_PORT_BIT = 2;
   localparam int STATE_TRIM_LSB = 8;
   // unlock keys for system_key_register
   localparam logic [7:0] KEY_CAUSE_CLEAR = 8'h71;
   localparam logic [7:0] KEY_PIN_SWITCH = 8'hb2;
   // reset vector address handed to the cpu
   localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
   // timing: least low time on the reset pin
   localparam int CLK_PERIOD_PS = 4000;
   localparam int PIN_LOW_MIN_US = 5;
   localparam int PIN_LOW_CYCLES = (PIN_LOW_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // default warm-up length and internal reset pulse length
   localparam int WARMUP_CYCLES_DEF = 1024;
   localparam int INT_RESET_CYCLES = 4;
endpackage

// >>> hw/rsc_pin_filter.sv
// module: low-level qualifier for the external reset pin
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_filter
   import rsc_pkg::*;
#(
   parameter int LOW_CYCLES = PIN_LOW_CYCLES
)
(
   // clock and root reset
   input wire logic clk,
   input wire logic rst_b,
   // pin low while reset function is on
   input wire logic pinLow,
   // qualified reset request
   output logic pinReset
);
   localparam int CW = $clog2(LOW_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(LOW_CYCLES - 1);
   logic [CW-1:0] lowCount;

   ////////////////////////////////////////////////////////////////////////
   // count low time; shorter glitches never reach the core
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lowCount <= '0;
         // held until the pin is first seen high: a board keeping it low holds the chip from power-up
         pinReset <= 1'b1;
      end
      else if (!pinLow)
      begin
         lowCount <= '0;
         pinReset <= 1'b0;
      end
      else if (lowCount == LAST)
         pinReset <= 1'b1;
      else
         lowCount <= lowCount + CW'(1);
   end

   AST_PIN_LOW_TIME: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(pinReset) |-> $past(lowCount) == LAST)
      else $error("pin reset raised before the low time");
endmodule // rsc_pin_filter
`default_nettype wire

// >>> hw/rsc_warmup.sv
// module: warm-up counter that gates start of the cpu
`timescale 1ns/1ps
`default_nettype none
module rsc_warmup
   import rsc_pkg::*;
#(
   parameter int CYCLES = WARMUP_CYCLES_DEF
)
(
   // clock and root reset
   input wire logic clk,
   input wire logic rst_b,
   // any reset source still active
   input wire logic hold,
   // warm-up state
   output logic busy,
   output logic done
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   logic [CW-1:0] count;

   ////////////////////////////////////////////////////////////////////////
   // any reset restarts the count from zero
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else if (hold)
      begin
         count <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else if (!done)
      begin
         busy <= (count != LAST);
         done <= (count == LAST);
         count <= count + CW'(1);
      end
   end

   AST_WARMUP_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
      hold |=> !done && count == '0)
      else $error("reset during warm-up did not restart the counter");
endmodule // rsc_warmup
`default_nettype wire

// >>> hw/rsc_reset_control.sv
// module: reset source combiner, cause status and reset pin control
`timescale 1ns/1ps
`default_nettype none
// Operation
// - por or pin reset gives chip reset
// - warm-up starts when last source releases
// - cpu and peripherals run after warm-up
// - pin low five microseconds causes reset
// - voltage detection raises internal reset
// - watchdog overflow raises internal reset
// - clock deadlock setting raises internal reset
// - trim bits loaded during warm-up, latched
// - abnormal trim load sets fault flag
// - corrupted latched trim raises internal reset
// - flash access in standby raises reset
// - cause register shows internal reset factor
// - cause cleared only by por, pin
// - clear request plus key 0x71 clears
// - disable bit plus key 0xb2: port
// - cleared bit plus key 0xb2: reset
// - switch pin function only while high (not checked: the keyed write switches at any pin level)
// - pin comes up as reset input
// - reset during warm-up restarts counter
// - cpu starts at reset vector 0xfffe
module rsc_reset_control
   import rsc_pkg::*;
#(
   parameter int WARMUP_CYCLES = WARMUP_CYCLES_DEF,
   parameter int TRIM_W = 8
)
(
   // clock and power-on reset (root, async)
   input wire logic clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // shared reset / port1_bit0 pin
   input wire logic resetPinIn,
   output logic port1Bit0In,
   // internal factor events
   input wire logic vltDetect,
   input wire logic wdtOverflow,
   input wire logic clkDeadlock,
   input wire logic flashStandbyAccess,
   // trimming data store
   input wire logic [TRIM_W-1:0] trimNvmData,
   input wire logic trimNvmBad,
   input wire logic trimCorrupt,
   output logic trimLoadEn,
   output logic [TRIM_W-1:0] trimLatch,
   // system reset and cpu start
   output logic sysReset,
   output logic cpuRun,
   output logic cpuStart,
   output logic [15:0] cpuFetchAddr
);
   logic [CAUSE_FLAGS-1:0] cause;
   logic [CAUSE_FLAGS-1:0] factorEvt;
   logic clearReq;
   logic pinDisReq;
   logic pinIsPort;
   logic pinReset;
   logic intReset;
   logic [2:0] intCount;
   logic wuBusy;
   logic wuDone;
   logic wrEn;
   logic keyWr;
   logic [7:0] keyVal;
   logic anyFactor;
   logic hold;

   // decode a word address, shared by read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // event collection
   always_comb
   begin
      factorEvt = '0;
      factorEvt[CAUSE_VLT_BIT] = vltDetect;
      factorEvt[CAUSE_WDT_BIT] = wdtOverflow;
      factorEvt[CAUSE_CLK_BIT] = clkDeadlock;
      factorEvt[CAUSE_TRIMLOST_BIT] = trimCorrupt && cpuRun;
      factorEvt[CAUSE_FLASH_BIT] = flashStandbyAccess;
   end
   assign anyFactor = |factorEvt;
   // por is the async root; pin and internal resets hold the warm-up counter, sysReset and the cpu outputs
   assign hold = pinReset || intReset;
   assign wrEn = psel && penable && pready && pwrite;
   assign keyWr = wrEn && hit(paddr, ADDR_KEY);
   assign keyVal = pwdata[7:0];

   ////////////////////////////////////////////////////////////////////////
   // pin qualifier; reset function is on unless switched to port
   rsc_pin_filter #(
      .LOW_CYCLES(PIN_LOW_CYCLES)
   ) uFilter (
      .clk(clk),
      .rst_b(rst_b),
      .pinLow(!resetPinIn && !pinIsPort),
      .pinReset(pinReset)
   );

   // warm-up counter, restarted by every reset source
   rsc_warmup #(
      .CYCLES(WARMUP_CYCLES)
   ) uWarmup (
      .clk(clk),
      .rst_b(rst_b),
      .hold(hold),
      .busy(wuBusy),
      .done(wuDone)
   );

   ////////////////////////////////////////////////////////////////////////
   // internal factor reset pulse, ignored while a pin or internal reset is active (accepted during warm-up)
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         intReset <= 1'b0;
         intCount <= '0;
      end
      else if (anyFactor && !pinReset && !intReset)
      begin
         intReset <= 1'b1;
         intCount <= 3'(INT_RESET_CYCLES - 1);
      end
      else if (intCount != '0)
         intCount <= intCount - 3'd1;
      else
         intReset <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // reset and run outputs
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sysReset <= 1'b1;
         cpuRun <= 1'b0;
         cpuStart <= 1'b0;
         cpuFetchAddr <= RESET_VECTOR_ADDR;
      end
      else
      begin
         sysReset <= hold || !wuDone;
         cpuRun <= wuDone && !hold;
         cpuStart <= wuDone && !hold && !cpuRun;
         cpuFetchAddr <= RESET_VECTOR_ADDR;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trimming data: loaded throughout warm-up, frozen afterwards
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         trimLoadEn <= 1'b0;
         trimLatch <= '0;
      end
      else
      begin
         trimLoadEn <= wuBusy;
         if (wuBusy)
            trimLatch <= trimNvmData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // cause status: por or pin clear it, internal resets keep it
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cause <= CAUSE_RESET;
         clearReq <= 1'b0;
      end
      else if (pinReset)
      begin
         cause <= CAUSE_RESET;
         clearReq <= 1'b0;
      end
      else
      begin
         // key clear first; events land after it so a set wins
         if (keyWr && keyVal == KEY_CAUSE_CLEAR && clearReq)
         begin
            cause <= CAUSE_RESET;
            clearReq <= 1'b0;
         end
         else if (wrEn && hit(paddr, ADDR_CAUSE))
            clearReq <= pwdata[CAUSE_CLEARREQ_BIT];
         if (!intReset)
         begin
            for (int i = 0; i < CAUSE_FLAGS; i++)
               if (factorEvt[i])
                  cause[i] <= 1'b1;
         end
         if (trimLoadEn && !wuBusy && trimNvmBad)
            cause[CAUSE_TRIMFAULT_BIT] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset pin function; only a keyed write moves the pin
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pinDisReq <= 1'b0;
         pinIsPort <= 1'b0;
      end
      else
      begin
         if (wrEn && hit(paddr, ADDR_SYSCTL3))
            pinDisReq <= pwdata[SYSCTL3_PINDIS_BIT];
         if (keyWr && keyVal == KEY_PIN_SWITCH)
            pinIsPort <= pinDisReq;
      end
   end

   // port read path is live only in port mode
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         port1Bit0In <= 1'b1;
      else
         port1Bit0In <= pinIsPort ? resetPinIn : 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, registered answer
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else if (psel && penable && !pready)
      begin
         pready <= 1'b1;
         pslverr <= !(hit(paddr, ADDR_CAUSE) || hit(paddr, ADDR_SYSCTL3) ||
                      hit(paddr, ADDR_KEY) || hit(paddr, ADDR_STATE));
         prdata <= '0;
         if (!pwrite)
         begin
            if (hit(paddr, ADDR_CAUSE))
            begin
               prdata[CAUSE_FLAGS-1:0] <= cause;
               prdata[CAUSE_CLEARREQ_BIT] <= clearReq;
            end
            if (hit(paddr, ADDR_SYSCTL3))
               prdata[SYSCTL3_PINDIS_BIT] <= pinDisReq;
            if (hit(paddr, ADDR_STATE))
            begin
               prdata[STATE_WARMUP_BIT] <= wuBusy;
               prdata[STATE_RUN_BIT] <= cpuRun;
               prdata[STATE_PORT_BIT] <= pinIsPort;
               prdata[STATE_TRIM_LSB +: TRIM_W] <= trimLatch;
            end
         end
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence keyClear;
      keyWr && keyVal == KEY_CAUSE_CLEAR && clearReq && !pinReset;
   endsequence
   sequence keySwitch;
      keyWr && keyVal == KEY_PIN_SWITCH;
   endsequence

   AST_PIN_RESETS: assert property (pinReset |=> sysReset && !cpuRun)
      else $error("pin reset did not hold the chip in reset");
   AST_RUN_AFTER_WARMUP: assert property ($rose(cpuRun) |-> $past(wuDone) && !sysReset)
      else $error("cpu ran before warm-up ended");
   AST_WARMUP_FROM_RELEASE: assert property ($fell(hold) |-> !wuDone [*2])
      else $error("warm-up skipped after release");
   AST_FACTOR_RESET: assert property ((anyFactor && !hold) |=> intReset ##1 sysReset)
      else $error("internal factor did not reset");
   AST_CAUSE_LATCH: assert property ((wdtOverflow && !hold) |=> cause[CAUSE_WDT_BIT])
      else $error("watchdog cause not recorded");
   AST_CAUSE_KEEP: assert property ((intReset && !pinReset && cause[CAUSE_VLT_BIT]) |=> cause[CAUSE_VLT_BIT])
      else $error("internal reset cleared the cause");
   AST_CAUSE_CLEAR: assert property ((keyClear and !anyFactor && !trimNvmBad) |=> cause == '0 && !clearReq)
      else $error("keyed clear failed");
   AST_WRONG_KEY: assert property ((keyWr && keyVal != KEY_PIN_SWITCH) |=> $stable(pinIsPort))
      else $error("pin function moved without its key");
   AST_PIN_SWITCH: assert property (keySwitch |=> pinIsPort == $past(pinDisReq))
      else $error("keyed pin switch failed");
   AST_TRIM_FROZEN: assert property (cpuRun && $past(cpuRun) |-> $stable(trimLatch))
      else $error("trim latch moved after warm-up");
   AST_VECTOR: assert property ($rose(cpuStart) |-> cpuFetchAddr == 16'hfffe)
      else $error("wrong reset vector");
endmodule // rsc_reset_control
`default_nettype wire

// >>> dv/rsc_board_model.sv
// board side model: reset supervisor driving the shared reset pin
`timescale 1ns/1ps
`default_nettype none
module rsc_board_model #(
   parameter int LOW_MIN = 1250
)
(
   // system clock
   input wire logic clk,
   // shared reset pin, pulled up on the board
   output logic resetPin
);
   ////////////////////////////////////////////////////////////////////////
   // slow supply: pin held low through power-up
   initial resetPin = 1'b0;
   // release once supply and oscillation are settled, then stay high
   task release_pin();
      repeat (LOW_MIN) @(posedge clk);
      resetPin <= 1'b1;
   endtask
   // low pulse never shorter than the least low time, ends stably high
   task pulse_low(input int n);
      int k;
      k = (n < LOW_MIN) ? LOW_MIN : n;
      resetPin <= 1'b0;
      repeat (k) @(posedge clk);
      resetPin <= 1'b1;
      @(posedge clk);
   endtask
endmodule // rsc_board_model
`default_nettype wire

// >>> dv/reset_source_control_tb.sv
// testbench of the reset source controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin failCount++; \
   $display("unexpected at %0t got %0h exp %0h", $time, got, exp); end end
module reset_source_control_tb;
   import rsc_pkg::*;
   logic clk, rstB, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, trimData, trimLatch;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0] ev;
   logic trimBad, pin, port1Bit0In, trimLoadEn, sysReset, cpuRun, cpuStart;
   logic [15:0] cpuFetchAddr;
   int failCount, checkCount, n, m;
   // event rows: vlt, wdt, clock, flash, trim corrupt
   localparam logic [4:0] EVS [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
   localparam logic [7:0] EXP [5] = '{8'h01, 8'h02, 8'h04, 8'h20, 8'h10};
   ////////////////////////////////////////////////////////////////////////
   // short warm-up keeps the run brief
   rsc_reset_control #(.WARMUP_CYCLES(16), .TRIM_W(8)) uut (.clk(clk), .rst_b(rstB), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .resetPinIn(pin), .port1Bit0In(port1Bit0In),
      .vltDetect(ev[0]), .wdtOverflow(ev[1]), .clkDeadlock(ev[2]), .flashStandbyAccess(ev[3]),
      .trimNvmData(trimData), .trimNvmBad(trimBad), .trimCorrupt(ev[4]), .trimLoadEn(trimLoadEn),
      .trimLatch(trimLatch), .sysReset(sysReset), .cpuRun(cpuRun), .cpuStart(cpuStart),
      .cpuFetchAddr(cpuFetchAddr));
   rsc_board_model #(.LOW_MIN(PIN_LOW_CYCLES)) board (.clk(clk), .resetPin(pin));
   // 250 MHz clock
   always #2 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   // one apb transfer; waits for pready, never assumes the wait count
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      @(posedge clk);
      while (pready !== 1'b1 && k < 20)
      begin
         @(posedge clk);
         k++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (k >= 20) failCount++;
   endtask
   // wait for reset, then for the cpu to run; warm-up must come first
   task wait_run();
      n = 0;
      m = 0;
      while (sysReset !== 1'b1 && n < 8)
      begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (cpuRun !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         n++;
         if (trimLoadEn === 1'b1) m++;
      end
      `CHK({cpuRun, cpuStart, sysReset, n >= 16, m > 0}, 5'b11011)
   endtask
   task finishTest();
      $display("checks %0d mismatches %0d", checkCount, failCount);
      if (failCount == 0 && checkCount > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // watchdog far beyond the expected run of under six thousand cycles
   initial
   begin
      repeat (40000) @(posedge clk);
      failCount++;
      finishTest();
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      {clk, rstB, psel, penable, pwrite, paddr, pwdata, ev, trimBad} = '0;
      trimData = 8'h5a;
      repeat (20) @(posedge clk);
      `CHK({sysReset, cpuRun, port1Bit0In, pready, cpuFetchAddr}, {4'b1010, 16'hfffe})
      rstB <= 1'b1;
      board.release_pin();
      `CHK({sysReset, cpuRun}, 2'b10)
      wait_run();
      $display("power-up done");
      // row loop: each internal factor, wrong key, then keyed clear
      for (int i = 0; i < 5; i++)
      begin
         ev <= EVS[i];
         @(posedge clk);
         ev <= 5'h00;
         wait_run();
         apb(1'b1, ADDR_CAUSE, 32'h80);
         apb(1'b1, ADDR_KEY, 32'h55);
         apb(1'b0, ADDR_CAUSE, 32'h0);
         `CHK(rd[7:0], EXP[i] | 8'h80)
         apb(1'b1, ADDR_KEY, {24'h0, KEY_CAUSE_CLEAR});
         apb(1'b0, ADDR_CAUSE, 32'h0);
         `CHK(rd[7:0], 8'h00)
      end
      $display("event rows done");
      // internal resets keep earlier causes; pin reset clears them
      ev <= 5'h02;
      @(posedge clk);
      ev <= 5'h00;
      wait_run();
      ev <= 5'h04;
      @(posedge clk);
      ev <= 5'h00;
      wait_run();
      apb(1'b0, ADDR_CAUSE, 32'h0);
      `CHK(rd[7:0], 8'h06)
      board.pulse_low(PIN_LOW_CYCLES);
      wait_run();
      apb(1'b0, ADDR_CAUSE, 32'h0);
      `CHK(rd[7:0], 8'h00)
      $display("pin reset done");
      // clock deadlock reset reruns warm-up, with an abnormal trim load during it
      trimData <= 8'h3c;
      trimBad <= 1'b1;
      ev <= 5'h04;
      @(posedge clk);
      ev <= 5'h00;
      wait_run();
      trimBad <= 1'b0;
      // new store data after warm-up must not reach the latch
      trimData <= 8'ha5;
      apb(1'b0, ADDR_CAUSE, 32'h0);
      `CHK(rd[7:0], 8'h0c)
      apb(1'b0, ADDR_STATE, 32'h0);
      `CHK({rd[15:8], trimLatch}, 16'h3c3c)
      $display("trim test done");
      // pin to port while high, low level ignored, then back to reset
      apb(1'b1, ADDR_SYSCTL3, 32'h1);
      apb(1'b1, ADDR_KEY, {24'h0, KEY_PIN_SWITCH});
      apb(1'b0, ADDR_STATE, 32'h0);
      `CHK(rd[2:0], 3'b110)
      // port read path follows the pin while it is low
      fork
         board.pulse_low(PIN_LOW_CYCLES + 20);
         begin
            repeat (8) @(posedge clk);
            `CHK(port1Bit0In, 1'b0)
         end
      join
      `CHK({sysReset, cpuRun}, 2'b01)
      apb(1'b1, ADDR_SYSCTL3, 32'h0);
      apb(1'b1, ADDR_KEY, {24'h0, KEY_PIN_SWITCH});
      apb(1'b0, ADDR_STATE, 32'h0);
      `CHK(rd[2], 1'b0)
      board.pulse_low(PIN_LOW_CYCLES);
      // sysReset follows the qualified pin reset one edge later
      @(posedge clk);
      `CHK(sysReset, 1'b1)
      wait_run();
      $display("pin switch done");
      // unmapped address refused
      apb(1'b0, 8'h40, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      // reset inside warm-up restarts the count
      rstB <= 1'b0;
      @(posedge clk);
      rstB <= 1'b1;
      repeat (8) @(posedge clk);
      rstB <= 1'b0;
      @(posedge clk);
      rstB <= 1'b1;
      wait_run();
      // internal reset inside warm-up restarts the count too
      ev <= 5'h04;
      @(posedge clk);
      ev <= 5'h00;
      repeat (12) @(posedge clk);
      ev <= 5'h01;
      @(posedge clk);
      ev <= 5'h00;
      wait_run();
      $display("warm-up restart done");
      finishTest();
   end
endmodule // reset_source_control_tb
`undef CHK
`default_nettype wire
